// >>> rtl/asr_pkg.sv
// shared constants, power-mode states and the state record of the status/reset/power block
package asr_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_ERROR = 8'h04;
  localparam logic [7:0] ADDR_SECT_COUNT = 8'h08;
  localparam logic [7:0] ADDR_SECT_NUM = 8'h0c;
  localparam logic [7:0] ADDR_CYL_LO = 8'h10;
  localparam logic [7:0] ADDR_CYL_HI = 8'h14;
  localparam logic [7:0] ADDR_DEV_HEAD = 8'h18;
  localparam logic [7:0] ADDR_COMMAND = 8'h1c;
  localparam logic [7:0] ADDR_DEV_CTRL = 8'h20;
  localparam logic [7:0] ADDR_ALT_STATUS = 8'h24;
  localparam logic [7:0] ADDR_DRIVE_EVENT = 8'h28;
  localparam logic [7:0] ADDR_POWER_REQ = 8'h2c;
  localparam logic [7:0] ADDR_FEATURES = 8'h30;
  localparam logic [7:0] ADDR_GEOMETRY = 8'h34;
  localparam logic [7:0] ADDR_PARAMS = 8'h38;
  localparam logic [7:0] ADDR_INFO = 8'h3c;
  localparam logic [7:0] ADDR_LBA = 8'h40;
  // status bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_FAULT = 5;
  localparam int ST_SEEK_DONE = 4;
  localparam int ST_DATA_REQ = 3;
  localparam int ST_CORRECTED = 2;
  localparam int ST_INDEX = 1;
  localparam int ST_ERROR = 0;
  // device control bits
  localparam int CTRL_SRST = 2;
  localparam int CTRL_NIEN = 1;
  // device/head fields
  localparam int DH_LBA_MODE = 6;
  // drive event bits, written by drive firmware
  localparam int EV_DONE = 0;
  localparam int EV_ERROR = 1;
  localparam int EV_SEEK_START = 2;
  localparam int EV_SEEK_DONE = 3;
  localparam int EV_DRQ_ON = 4;
  localparam int EV_DRQ_OFF = 5;
  localparam int EV_INIT_DONE = 6;
  localparam int EV_DIAG_DONE = 7;
  // task register values after any reset
  localparam logic [7:0] RST_SECT_COUNT = 8'h01;
  localparam logic [7:0] RST_SECT_NUM = 8'h01;
  localparam logic [7:0] RST_CYL = 8'h00;
  localparam logic [7:0] RST_DEV_HEAD = 8'ha0;
  localparam logic [7:0] RST_STATUS = 8'h50;
  // diagnostic codes
  localparam logic [7:0] DIAG_NO_ERROR = 8'h01;
  localparam logic [7:0] DIAG_FORMATTER = 8'h02;
  localparam logic [7:0] DIAG_BUFFER = 8'h03;
  localparam logic [7:0] DIAG_ECC = 8'h04;
  localparam logic [7:0] DIAG_CPU = 8'h05;
  localparam logic [7:0] FEAT_REVERT_ON = 8'hcc;
  // software reset hold time
  localparam int CLK_PERIOD_NS = 10;
  localparam int SRST_HOLD_NS = 5000;
  localparam logic [9:0] SRST_HOLD_CYC = 10'((SRST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [3:0] {
    PM_ACTIVE = 4'b0001,
    PM_IDLE = 4'b0010,
    PM_STANDBY = 4'b0100,
    PM_SLEEP = 4'b1000
  } asr_pmode_type;

  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic [3:0] sy3;
    logic [3:0] flt;
    logic link_prev;
    logic busy;
    logic ready;
    logic dsc;
    logic dsc_live;
    logic dsc_frozen;
    logic drq;
    logic err;
    logic irq_pend;
    logic intrq;
    logic nien;
    logic srst;
    logic [9:0] srst_cnt;
    logic [7:0] sect_count;
    logic [7:0] sect_num;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] dev_head;
    logic [7:0] features;
    logic [7:0] command;
    logic [7:0] error;
    logic [7:0] diag_code;
    logic [7:0] heads;
    logic [7:0] spt;
    logic [7:0] mult;
    logic wcache;
    logic rla;
    logic [7:0] ecc;
    logic revert_en;
    asr_pmode_type pmode;
    logic [7:0] tmr_count;
    logic tmr_run;
    logic [15:0] tmr_pre;
    logic [7:0] tmr_left;
    logic por_pend;
    logic abort_dev_pend;
    logic abort_host;
    logic abort_device;
    logic spin_up;
    logic cmd_start;
    logic iface_active;
    logic [27:0] lba;
    logic chs_bad;
  } asr_state_type;
endpackage : asr_pkg

// >>> rtl/asr_ctrl.sv
// status register, reset response, addressing and power modes of the drive task file
// Contract
// - status byte holds busy, ready, fault, seek, drq, corrected, index, error bits
// - reading status acknowledges and clears the pending interrupt
// - while busy, a read of any task register up to device/head returns status
// - ready low through power-on; after error low until status read
// - fault and corrected read zero; no service indication
// - seek bit tracks seeks, frozen after error, forced in standby and sleep
// - data request shows word readiness; host must not write command meanwhile
// - index bit pulses once per revolution
// - error bit set on failed command, cleared when next command arrives
// - three resets: power-on, link reset, software reset bit set then cleared
// - link/soft reset aborts host side, device side after cache flush
// - only power-on runs init, diagnostics, spin-up, disables standby timer
// - parameter defaults on power-on; link/soft only after revert enabled by CCh
// - link/soft reset moves sleep to standby, other modes unchanged
// - after power-on enter idle, or standby if power-up-in-standby strapped
// - task registers load fixed defaults after any reset
// - every reset and diagnostic command leaves a diagnostic code in error
// - device/head mode bit selects CHS at 0, LBA at 1
// - CHS sector 1..spt, head below heads, cylinder up to 65535
// - LBA bits spread over head field, cylinder high, cylinder low, sector
// - idle and standby requests move modes; non-immediate forms load timer
// - after sleep interface goes inactive until reset, then standby
module asr_ctrl #(
  parameter logic [7:0] HEADS_DEF = 8'd16,
  parameter logic [7:0] SPT_DEF = 8'd63,
  parameter logic [7:0] MULT_DEF = 8'd16,
  parameter logic [7:0] ECC_DEF = 8'd4,
  parameter logic [7:0] SET_FEAT_CMD = 8'hef,
  parameter logic [15:0] TMR_TICK_CYC = 16'd5000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic link_reset_pin,
  input wire logic index_pin,
  input wire logic cache_dirty,
  input wire logic standby_strap,
  output logic intrq,
  output logic abort_host,
  output logic abort_device,
  output logic spin_up,
  output logic cmd_start,
  output logic interface_active
);
  asr_pkg::asr_state_type s;
  asr_pkg::asr_state_type n;
  logic acc;
  logic link_evt;
  logic soft_evt;
  logic in_sleep;
  logic low_power;
  logic [7:0] status;
  logic [31:0] rd;
  logic [31:0] ev;
  logic ev_wr;
  logic st_read;
  logic [23:0] cyl_heads;
  logic [31:0] chs_lba;

  always_comb begin
    n = s;
    acc = hsel && htrans[1] && hready;
    ev = 32'h0000_0000;
    ev_wr = 1'b0;
    st_read = 1'b0;
    link_evt = 1'b0;
    soft_evt = 1'b0;
    rd = 32'h0000_0000;
    in_sleep = (s.pmode == asr_pkg::PM_SLEEP);
    low_power = in_sleep || (s.pmode == asr_pkg::PM_STANDBY);
    cyl_heads = 24'({s.cyl_hi, s.cyl_lo} * s.heads);
    chs_lba = 32'((cyl_heads + 24'(s.dev_head[3:0])) * s.spt) + 32'(s.sect_num) - 32'd1;
    // pins pass three stages; a change counts once stages two and three agree
    n.sy1 = {standby_strap, cache_dirty, index_pin, link_reset_pin};
    n.sy2 = s.sy1;
    n.sy3 = s.sy2;
    n.flt = (s.sy2 & s.sy3) | (s.flt & (s.sy2 | s.sy3));
    n.link_prev = s.flt[0];
    link_evt = s.flt[0] && !s.link_prev;
    n.abort_host = 1'b0;
    n.abort_device = 1'b0;
    n.cmd_start = 1'b0;
    n.hreadyout = 1'b1;
    n.hresp = 1'b0;
    // status byte; fault, corrected stay zero, seek is forced in low-power modes
    status = 8'h00;
    status[asr_pkg::ST_BUSY] = s.busy || s.srst;
    status[asr_pkg::ST_READY] = s.ready;
    status[asr_pkg::ST_FAULT] = 1'b0;
    status[asr_pkg::ST_SEEK_DONE] = s.dsc || low_power;
    status[asr_pkg::ST_DATA_REQ] = s.drq;
    status[asr_pkg::ST_CORRECTED] = 1'b0;
    status[asr_pkg::ST_INDEX] = s.flt[1];
    status[asr_pkg::ST_ERROR] = s.err;
    n.lba = s.dev_head[asr_pkg::DH_LBA_MODE] ?
            {s.dev_head[3:0], s.cyl_hi, s.cyl_lo, s.sect_num} : chs_lba[27:0];
    n.chs_bad = !s.dev_head[asr_pkg::DH_LBA_MODE] && (s.sect_num == 8'h00 ||
                s.sect_num > s.spt || {4'h0, s.dev_head[3:0]} >= s.heads);
    // standby timer, prescaled; runs only after an idle request started it
    if (s.tmr_run && s.tmr_count != 8'h00) begin
      if (s.tmr_pre >= TMR_TICK_CYC - 16'd1) begin
        n.tmr_pre = 16'h0000;
        if (s.tmr_left != 8'h00) begin
          n.tmr_left = s.tmr_left - 8'h01;
        end else if (s.pmode == asr_pkg::PM_ACTIVE || s.pmode == asr_pkg::PM_IDLE) begin
          n.pmode = asr_pkg::PM_STANDBY;
          n.dsc_live = 1'b1;
        end
      end else begin
        n.tmr_pre = s.tmr_pre + 16'h0001;
      end
    end
    if (s.srst && s.srst_cnt != asr_pkg::SRST_HOLD_CYC) begin
      n.srst_cnt = s.srst_cnt + 10'h001;
    end
    // data phase of a write
    if (s.wr_pend) begin
      n.wr_pend = 1'b0;
      case (s.wr_addr)
        asr_pkg::ADDR_DEV_CTRL: begin
          n.nien = hwdata[asr_pkg::CTRL_NIEN];
          n.srst = hwdata[asr_pkg::CTRL_SRST];
          if (!hwdata[asr_pkg::CTRL_SRST]) begin
            n.srst_cnt = 10'h000;
          end
          // a pulse shorter than the hold time is not taken as a reset
          if (s.srst && !hwdata[asr_pkg::CTRL_SRST] && s.srst_cnt == asr_pkg::SRST_HOLD_CYC) begin
            soft_evt = 1'b1;
          end
        end
        asr_pkg::ADDR_SECT_COUNT: begin
          if (!s.busy && !in_sleep) begin
            n.sect_count = hwdata[7:0];
          end
        end
        asr_pkg::ADDR_SECT_NUM: begin
          if (!s.busy && !in_sleep) begin
            n.sect_num = hwdata[7:0];
          end
        end
        asr_pkg::ADDR_CYL_LO: begin
          if (!s.busy && !in_sleep) begin
            n.cyl_lo = hwdata[7:0];
          end
        end
        asr_pkg::ADDR_CYL_HI: begin
          if (!s.busy && !in_sleep) begin
            n.cyl_hi = hwdata[7:0];
          end
        end
        asr_pkg::ADDR_DEV_HEAD: begin
          if (!s.busy && !in_sleep) begin
            n.dev_head = hwdata[7:0];
          end
        end
        asr_pkg::ADDR_FEATURES: begin
          if (!s.busy && !in_sleep) begin
            n.features = hwdata[7:0];
          end
        end
        asr_pkg::ADDR_COMMAND: begin
          // ignored while busy, during data request, or with the interface asleep
          if (!s.busy && !s.drq && !in_sleep && s.ready) begin
            n.command = hwdata[7:0];
            n.busy = 1'b1;
            n.err = 1'b0;
            n.cmd_start = 1'b1;
            n.tmr_left = s.tmr_count;
            n.tmr_pre = 16'h0000;
            if (s.pmode != asr_pkg::PM_ACTIVE) begin
              n.pmode = asr_pkg::PM_ACTIVE;
            end
            if (hwdata[7:0] == SET_FEAT_CMD && s.features == asr_pkg::FEAT_REVERT_ON) begin
              n.revert_en = 1'b1;
            end
          end
        end
        asr_pkg::ADDR_DRIVE_EVENT: begin
          ev = hwdata;
          ev_wr = 1'b1;
        end
        asr_pkg::ADDR_POWER_REQ: begin
          if (hwdata[1:0] == 2'd0 && s.pmode != asr_pkg::PM_SLEEP) begin
            n.pmode = asr_pkg::PM_IDLE;
            if (!hwdata[2]) begin
              n.tmr_count = hwdata[15:8];
              n.tmr_left = hwdata[15:8];
              n.tmr_pre = 16'h0000;
              n.tmr_run = 1'b1;
            end
          end else if (hwdata[1:0] == 2'd1 && s.pmode != asr_pkg::PM_SLEEP) begin
            n.pmode = asr_pkg::PM_STANDBY;
            n.dsc_live = 1'b1;
            if (!hwdata[2]) begin
              n.tmr_count = hwdata[15:8];
              n.tmr_left = hwdata[15:8];
            end
          end else if (hwdata[1:0] == 2'd2) begin
            n.pmode = asr_pkg::PM_SLEEP;
            n.dsc_live = 1'b1;
            n.iface_active = 1'b0;
          end
        end
        asr_pkg::ADDR_GEOMETRY: begin
          n.heads = hwdata[7:0];
          n.spt = hwdata[15:8];
        end
        asr_pkg::ADDR_PARAMS: begin
          n.mult = hwdata[7:0];
          n.wcache = hwdata[8];
          n.rla = hwdata[9];
          n.ecc = hwdata[23:16];
        end
        default: begin
        end
      endcase
    end
    // address phase: reads answer in the following data phase
    if (acc && hwrite) begin
      n.wr_pend = 1'b1;
      n.wr_addr = haddr[7:0];
    end else if (acc) begin
      case (haddr[7:0])
        asr_pkg::ADDR_STATUS: begin
          rd = {24'h000000, status};
          st_read = 1'b1;
        end
        asr_pkg::ADDR_ALT_STATUS: rd = {24'h000000, status};
        asr_pkg::ADDR_ERROR: rd = {24'h000000, s.error};
        asr_pkg::ADDR_SECT_COUNT: rd = {24'h000000, s.sect_count};
        asr_pkg::ADDR_SECT_NUM: rd = {24'h000000, s.sect_num};
        asr_pkg::ADDR_CYL_LO: rd = {24'h000000, s.cyl_lo};
        asr_pkg::ADDR_CYL_HI: rd = {24'h000000, s.cyl_hi};
        asr_pkg::ADDR_DEV_HEAD: rd = {24'h000000, s.dev_head};
        asr_pkg::ADDR_FEATURES: rd = {24'h000000, s.features};
        asr_pkg::ADDR_COMMAND: rd = {24'h000000, s.command};
        asr_pkg::ADDR_GEOMETRY: rd = {16'h0000, s.spt, s.heads};
        asr_pkg::ADDR_PARAMS: rd = {8'h00, s.ecc, 6'h00, s.rla, s.wcache, s.mult};
        asr_pkg::ADDR_INFO: rd = {16'h0000, s.tmr_count, s.chs_bad, s.abort_dev_pend,
                                  s.revert_en, s.irq_pend, s.pmode};
        asr_pkg::ADDR_LBA: rd = {4'h0, s.lba};
        default: rd = 32'h0000_0000;
      endcase
      // task registers hide behind status while busy
      if (status[asr_pkg::ST_BUSY] && haddr[7:0] <= asr_pkg::ADDR_DEV_HEAD) begin
        rd = {24'h000000, status};
      end
    end
    if (acc && !hwrite) begin
      n.hrdata = rd;
    end
    if (st_read) begin
      n.irq_pend = 1'b0;
      if (!s.por_pend) begin
        n.ready = 1'b1;
      end
      n.dsc_frozen = 1'b0;
      n.dsc = s.dsc_live;
    end
    // firmware events come after the read clear so a same-cycle set wins
    if (ev_wr) begin
      if (ev[asr_pkg::EV_SEEK_START]) begin
        n.dsc_live = 1'b0;
      end
      if (ev[asr_pkg::EV_SEEK_DONE]) begin
        n.dsc_live = 1'b1;
      end
      if (ev[asr_pkg::EV_DRQ_ON]) begin
        n.drq = 1'b1;
      end
      if (ev[asr_pkg::EV_DRQ_OFF]) begin
        n.drq = 1'b0;
      end
      if (ev[asr_pkg::EV_DONE]) begin
        n.busy = 1'b0;
        n.irq_pend = 1'b1;
      end
      if (ev[asr_pkg::EV_ERROR]) begin
        n.busy = 1'b0;
        n.err = 1'b1;
        n.ready = 1'b0;
        n.dsc_frozen = 1'b1;
        n.drq = 1'b0;
        n.error = ev[15:8];
        n.irq_pend = 1'b1;
      end
      if (ev[asr_pkg::EV_DIAG_DONE]) begin
        n.diag_code = ev[23:16];
        n.error = ev[23:16];
      end
      if (ev[asr_pkg::EV_INIT_DONE] && s.por_pend) begin
        n.por_pend = 1'b0;
        n.spin_up = 1'b0;
        n.busy = 1'b0;
        n.ready = 1'b1;
        n.dsc = 1'b1;
        n.dsc_live = 1'b1;
        n.pmode = s.flt[3] ? asr_pkg::PM_STANDBY : asr_pkg::PM_IDLE;
      end
    end
    if (!n.dsc_frozen) begin
      n.dsc = n.dsc_live;
    end
    // link and software reset: interface only, no diagnostics or spin-up
    if ((link_evt || soft_evt) && !s.por_pend) begin
      n.abort_host = 1'b1;
      n.abort_dev_pend = 1'b1;
      n.busy = 1'b0;
      n.drq = 1'b0;
      n.err = RST_STATUS_BIT(asr_pkg::ST_ERROR);
      n.ready = RST_STATUS_BIT(asr_pkg::ST_READY);
      n.dsc = RST_STATUS_BIT(asr_pkg::ST_SEEK_DONE);
      n.dsc_live = n.dsc;
      n.dsc_frozen = 1'b0;
      n.irq_pend = 1'b0;
      n.sect_count = asr_pkg::RST_SECT_COUNT;
      n.sect_num = asr_pkg::RST_SECT_NUM;
      n.cyl_lo = asr_pkg::RST_CYL;
      n.cyl_hi = asr_pkg::RST_CYL;
      n.dev_head = asr_pkg::RST_DEV_HEAD;
      n.error = s.diag_code;
      n.iface_active = 1'b1;
      if (s.revert_en) begin
        n.heads = HEADS_DEF;
        n.spt = SPT_DEF;
        n.mult = MULT_DEF;
        n.wcache = 1'b1;
        n.rla = 1'b1;
        n.ecc = ECC_DEF;
      end
      if (s.pmode == asr_pkg::PM_SLEEP) begin
        n.pmode = asr_pkg::PM_STANDBY;
      end else begin
        n.pmode = s.pmode;
      end
    end
    // device side stops only once cached writes reached the media
    if (s.abort_dev_pend && !s.flt[2]) begin
      n.abort_dev_pend = 1'b0;
      n.abort_device = 1'b1;
    end
    n.intrq = n.irq_pend && !n.nien;
  end

  function automatic logic RST_STATUS_BIT(input int pos);
    return asr_pkg::RST_STATUS[pos];
  endfunction : RST_STATUS_BIT

  // power-on reset: defaults, timer off, spin-up and diagnostics requested
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.busy <= 1'b1;
      s.ready <= 1'b0;
      s.por_pend <= 1'b1;
      s.spin_up <= 1'b1;
      s.tmr_run <= 1'b0;
      s.hreadyout <= 1'b1;
      s.sect_count <= asr_pkg::RST_SECT_COUNT;
      s.sect_num <= asr_pkg::RST_SECT_NUM;
      s.cyl_lo <= asr_pkg::RST_CYL;
      s.cyl_hi <= asr_pkg::RST_CYL;
      s.dev_head <= asr_pkg::RST_DEV_HEAD;
      s.error <= asr_pkg::DIAG_NO_ERROR;
      s.diag_code <= asr_pkg::DIAG_NO_ERROR;
      s.heads <= HEADS_DEF;
      s.spt <= SPT_DEF;
      s.mult <= MULT_DEF;
      s.wcache <= 1'b1;
      s.rla <= 1'b1;
      s.ecc <= ECC_DEF;
      s.pmode <= asr_pkg::PM_ACTIVE;
      s.iface_active <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign intrq = s.intrq;
  assign abort_host = s.abort_host;
  assign abort_device = s.abort_device;
  assign spin_up = s.spin_up;
  assign cmd_start = s.cmd_start;
  assign interface_active = s.iface_active;
endmodule : asr_ctrl

// >>> dv/asr_ctrl_assertions.sv
// concurrent checks on the task-file control block ports
module asr_ctrl_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic intrq,
  input wire logic abort_host,
  input wire logic abort_device,
  input wire logic spin_up,
  input wire logic cmd_start,
  input wire logic interface_active
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic take = hsel & htrans[1] & hready;
  wire logic rd_st = take & !hwrite & (haddr[7:0] == asr_pkg::ADDR_STATUS);
  wire logic rd_alt = take & !hwrite & (haddr[7:0] == asr_pkg::ADDR_ALT_STATUS);
  wire logic wr_cmd = take & hwrite & (haddr[7:0] == asr_pkg::ADDR_COMMAND);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  irq_ack_a: assert property (rd_st |-> ##[1:2] !intrq)
    else $error("interrupt still pending after status read");
  status_bits_a: assert property ($past(rd_st | rd_alt) |->
    hrdata[31:8] == 24'h0 && !hrdata[5] && !hrdata[2])
    else $error("status fault or corrected bit set");
  host_abort_a: assert property (abort_host |=> !abort_host)
    else $error("host abort longer than one cycle");
  dev_abort_a: assert property (abort_device |=> !abort_device)
    else $error("device abort longer than one cycle");
  cmd_cause_a: assert property (cmd_start |->
    $past(wr_cmd) || $past(wr_cmd, 2) || $past(wr_cmd, 3))
    else $error("command start without command write");
  spin_once_a: assert property (!spin_up |=> !spin_up)
    else $error("spin-up outside power-on");
  wake_cause_a: assert property ($rose(interface_active) |->
    abort_host || $past(abort_host) || $past(abort_host, 2))
    else $error("interface woke without a reset");
  sleep_quiet_a: assert property (!interface_active |-> !cmd_start)
    else $error("command started while asleep");
  cover property (rd_st);
  cover property (abort_host);
  cover property (abort_device);
  cover property (!interface_active);
endmodule : asr_ctrl_chk

// >>> dv/asr_host_model.sv
// host adapter model issuing link reset requests
module asr_host_model (
  input wire logic hclk,
  input wire logic go,
  output logic link_reset_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left = 4'h0;
  // held several cycles so the input synchroniser cannot miss it
  always @(posedge hclk) begin
    if (go) left <= 4'h8;
    else if (left != 4'h0) left <= left - 4'h1;
  end
  assign link_reset_pin = (left != 4'h0);
endmodule : asr_host_model

// >>> dv/asr_ctrl_test.sv
// self-checking bench for the task-file control block
module asr_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, index_pin = 0, cache_dirty = 0;
  logic go = 0, standby_strap = 0, seen;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic hreadyout, hresp, link_reset_pin, intrq, abort_host, abort_device;
  logic spin_up, cmd_start, iface;
  int bad_count = 0, compares = 0;
  logic [15:0] dflt [8] = '{16'h0050, 16'h0401, 16'h0801, 16'h0c01,
    16'h1000, 16'h1400, 16'h18a0, 16'h2450};
  logic [31:0] pm [3] = '{32'h0005_0004, 32'h0004_0002, 32'h0301_0304};
  // standby timer shortened so the expiry fits in a few dozen cycles
  asr_ctrl #(.TMR_TICK_CYC(16'd10)) DUT (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .link_reset_pin, .index_pin, .cache_dirty, .standby_strap,
    .intrq, .abort_host, .abort_device, .spin_up, .cmd_start,
    .interface_active(iface));
  asr_host_model host (.hclk, .go, .link_reset_pin);
  initial forever #5 hclk = ~hclk;
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    q = hrdata;
    if (n >= 100) begin
      bad_count++;
      wrap_up();
    end
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask : rd
  // collects a one-cycle pulse over a bounded number of edges
  task watch(input int k, input int c);
    seen = 1'b0;
    repeat (c) begin
      @(posedge hclk);
      seen = seen | (k == 0 ? cmd_start : k == 1 ? abort_host : abort_device);
    end
  endtask : watch
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h00, 32'hff, 32'h80);
    rd(8'h08, 32'hff, 32'h80);
    chk(spin_up, 32'h1);
    chk({hreadyout, hresp}, 32'h2);
    // task registers stay untouched until init done clears busy
    wr(8'h28, 32'h40);
    foreach (dflt[i]) rd(dflt[i][15:8], 32'hff, {24'h0, dflt[i][7:0]});
    rd(8'h3c, 32'hf, 32'h2);
    $display("test reset done");
    wr(8'h18, 32'he5);
    wr(8'h14, 32'h34);
    wr(8'h10, 32'h56);
    wr(8'h0c, 32'h78);
    rd(8'h18, 32'h40, 32'h40);
    rd(8'h40, 32'hfffffff, 32'h5345678);
    wr(8'h18, 32'ha2);
    wr(8'h14, 32'h0);
    wr(8'h10, 32'h1);
    wr(8'h0c, 32'h3);
    rd(8'h0c, 32'hff, 32'h3);
    rd(8'h40, 32'hfffffff, 32'd1136);
    wr(8'h0c, 32'h0);
    // range flag is registered, so one read passes before it is looked at
    rd(8'h0c, 32'hff, 32'h0);
    rd(8'h3c, 32'h80, 32'h80);
    $display("test addressing done");
    wr(8'h28, 32'h10);
    rd(8'h24, 32'h08, 32'h08);
    wr(8'h1c, 32'h20);
    watch(0, 4);
    chk(seen, 32'h0);
    wr(8'h28, 32'h20);
    rd(8'h24, 32'h08, 32'h0);
    wr(8'h28, 32'h04);
    rd(8'h24, 32'h10, 32'h0);
    wr(8'h28, 32'h08);
    rd(8'h24, 32'h10, 32'h10);
    index_pin <= 1'b1;
    repeat (5) @(posedge hclk);
    rd(8'h24, 32'h02, 32'h02);
    index_pin <= 1'b0;
    $display("test status bits done");
    wr(8'h1c, 32'h20);
    watch(0, 4);
    chk(seen, 32'h1);
    wr(8'h28, 32'h0402);
    rd(8'h24, 32'hc1, 32'h01);
    rd(8'h04, 32'hff, 32'h04);
    chk(intrq, 32'h1);
    rd(8'h00, 32'hc1, 32'h01);
    repeat (2) @(posedge hclk);
    chk(intrq, 32'h0);
    rd(8'h24, 32'hc1, 32'h41);
    wr(8'h1c, 32'h20);
    rd(8'h24, 32'h01, 32'h0);
    wr(8'h28, 32'h01);
    $display("test command error done");
    foreach (pm[i]) begin
      wr(8'h2c, {16'h0, pm[i][31:16]});
      rd(8'h3c, 32'hff0f, {16'h0, pm[i][15:0]});
    end
    rd(8'h24, 32'h10, 32'h10);
    wr(8'h2c, 32'h0100);
    rd(8'h3c, 32'hf, 32'h2);
    repeat (40) @(posedge hclk);
    rd(8'h3c, 32'hf, 32'h4);
    wr(8'h2c, 32'h2);
    rd(8'h3c, 32'hf, 32'h8);
    chk(iface, 32'h0);
    wr(8'h1c, 32'h20);
    watch(0, 4);
    chk(seen, 32'h0);
    wr(8'h20, 32'h4);
    repeat (500) @(posedge hclk);
    wr(8'h20, 32'h0);
    watch(1, 4);
    chk(seen, 32'h1);
    rd(8'h3c, 32'hf, 32'h4);
    chk(iface, 32'h1);
    wr(8'h28, 32'h03_0080);
    rd(8'h04, 32'hff, 32'h03);
    rd(8'h08, 32'hff, 32'h01);
    wr(8'h30, 32'hcc);
    wr(8'h1c, 32'hef);
    wr(8'h28, 32'h01);
    wr(8'h2c, 32'h05);
    wr(8'h34, 32'h0402);
    rd(8'h34, 32'hffff, 32'h0402);
    $display("test power and soft reset done");
    cache_dirty <= 1'b1;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    watch(1, 12);
    chk(seen, 32'h1);
    watch(2, 10);
    chk(seen, 32'h0);
    cache_dirty <= 1'b0;
    watch(2, 10);
    chk(seen, 32'h1);
    rd(8'h3c, 32'hf, 32'h4);
    rd(8'h34, 32'hffff, 32'h3f10);
    $display("test link reset done");
    // second power-on with the strap set; the strap needs its sync stages first
    standby_strap <= 1'b1;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (5) @(posedge hclk);
    rd(8'h00, 32'hff, 32'h80);
    wr(8'h28, 32'h40);
    rd(8'h3c, 32'hf, 32'h4);
    rd(8'h00, 32'hff, 32'h50);
    $display("test power-on standby done");
    wrap_up();
  end
endmodule : asr_ctrl_test
bind asr_ctrl asr_ctrl_chk chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .intrq, .abort_host, .abort_device, .spin_up, .cmd_start,
  .interface_active);
